// *** inc/frame_sched_pkg.sv ***
// Constants and carriers for the cyclic frame transmit scheduler.
// Assumes a single 200 MHz clock and a host that writes registers over a plain strobe port.
package frame_sched_pkg;
    localparam int unsigned CLK_FREQ_HZ = 200_000_000;
    localparam int unsigned TICK_NS = 1000;
    localparam int unsigned TICK_CYCLES = (TICK_NS * (CLK_FREQ_HZ / 1_000_000) + 999) / 1000;

    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_DELAY = 4'h1;
    localparam logic [3:0] ADDR_PERIOD = 4'h2;
    localparam logic [3:0] ADDR_CORRUPT = 4'h3;
    localparam logic [3:0] ADDR_SKIP = 4'h4;
    localparam logic [3:0] ADDR_ID = 4'h5;
    localparam logic [3:0] ADDR_STATUS = 4'h6;
    localparam logic [3:0] ADDR_QSIZE = 4'h7;

    localparam int unsigned CTRL_START_BIT = 0;
    localparam int unsigned CTRL_STOP_BIT = 1;
    localparam int unsigned CTRL_EVENT_BIT = 2;
    localparam int unsigned CTRL_SPOINT_BIT = 3;

    localparam logic [31:0] DELAY_RST = 32'hFFFFFFFF;
    localparam logic [31:0] PERIOD_RST = 32'h000003E8;
    localparam logic [31:0] COUNT_RST = 32'h00000000;
    localparam logic [31:0] ID_RST = 32'h00000000;

    typedef enum logic [1:0] {
        SLOT_UNCOND = 2'b00,
        SLOT_SPORADIC = 2'b01,
        SLOT_EVENT = 2'b10,
        SLOT_RESOLVE = 2'b11
    } slot_kind_e;

    typedef struct packed {
        slot_kind_e kind;
        logic collision;
        logic [7:0] checksum;
    } lin_slot_s;

    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;
endpackage : frame_sched_pkg

// *** rtl/frame_tx_scheduler.sv ***
// Cyclic frame transmit timing, skip injection and LIN checksum corruption.
// Assumes synchronous inputs, a host on the register port, and a framer that reports LIN slots.
`timescale 1ns/1ps
`default_nettype none
module frame_tx_scheduler #(
    parameter int unsigned CW = 32
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic clk_en_i,
    // Register port
    input wire frame_sched_pkg::reg_req_s req_i,
    output logic [31:0] rdata_o,
    // Cyclic transmit side
    output logic tx_due_o,
    output logic tx_skip_o,
    output logic dequeue_o,
    // LIN slot side
    input wire logic lin_slot_i,
    input wire frame_sched_pkg::lin_slot_s lin_i,
    output logic [7:0] lin_checksum_o,
    output logic lin_corrupt_o
);
    import frame_sched_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_FIRST = 2'b01,
        ST_CYCLIC = 2'b10
    } sched_e;

    sched_e state_q;
    logic [CW-1:0] delay_cfg_q, period_q, corrupt_q, skip_q, ident_q, count_q, qsize_q;
    logic qsize_set_q, event_q, spoint_q;
    logic [15:0] tick_cnt_q;
    logic tick;
    logic [CW-1:0] derived_delay, first_delay;
    logic start_cmd, stop_cmd, period_wr, restart, due, do_skip;
    logic lin_decr;

    assign tick = (tick_cnt_q == 16'(TICK_CYCLES - 1));
    assign start_cmd = req_i.wr && req_i.addr == ADDR_CTRL && req_i.wdata[CTRL_START_BIT];
    assign stop_cmd = req_i.wr && req_i.addr == ADDR_CTRL && req_i.wdata[CTRL_STOP_BIT];
    assign period_wr = req_i.wr && req_i.addr == ADDR_PERIOD;
    // Period change while running restarts the frame
    assign restart = start_cmd || (period_wr && state_q != ST_IDLE);
    // Stagger by the whole identifier modulo the period so frames spread out
    assign derived_delay = (period_q == '0) ? '0 : (ident_q % period_q);
    assign first_delay = delay_cfg_q[CW-1] ? derived_delay : delay_cfg_q;
    // A stop or restart in the due cycle wins, so no stray send or skip
    assign due = (state_q != ST_IDLE) && tick && (count_q <= CW'(1)) && !event_q && !restart && !stop_cmd;
    assign do_skip = due && (skip_q != '0);

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tick_cnt_q <= 16'h0000;
        end else if (clk_en_i) begin
            if (restart || tick) begin
                tick_cnt_q <= 16'h0000;
            end else begin
                tick_cnt_q <= tick_cnt_q + 16'h0001;
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            delay_cfg_q <= CW'(DELAY_RST);
            period_q <= CW'(PERIOD_RST);
            ident_q <= CW'(ID_RST);
            event_q <= 1'b0;
            spoint_q <= 1'b0;
        end else if (clk_en_i && req_i.wr) begin
            unique case (req_i.addr)
                ADDR_DELAY: delay_cfg_q <= req_i.wdata[CW-1:0];
                ADDR_PERIOD: period_q <= req_i.wdata[CW-1:0];
                ADDR_ID: ident_q <= req_i.wdata[CW-1:0];
                ADDR_CTRL: begin
                    event_q <= req_i.wdata[CTRL_EVENT_BIT];
                    spoint_q <= req_i.wdata[CTRL_SPOINT_BIT];
                end
                default: ;
            endcase
        end
    end

    // A period-write restart derives the first delay from the freshly written period in the write data, in the same cycle, not from period_q
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_q <= ST_IDLE;
            count_q <= '0;
        end else if (clk_en_i) begin
            if (stop_cmd && !start_cmd) begin
                state_q <= ST_IDLE;
            end else if (restart) begin
                state_q <= ST_FIRST;
                count_q <= period_wr ? ((delay_cfg_q[CW-1] && req_i.wdata[CW-1:0] != '0) ?
                    ident_q % req_i.wdata[CW-1:0] : (delay_cfg_q[CW-1] ? '0 : delay_cfg_q)) :
                    first_delay;
            end else if (state_q != ST_IDLE && tick) begin
                if (count_q <= CW'(1)) begin
                    state_q <= ST_CYCLIC;
                    count_q <= period_q;
                end else begin
                    count_q <= count_q - CW'(1);
                end
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            skip_q <= CW'(COUNT_RST);
        end else if (clk_en_i) begin
            if (req_i.wr && req_i.addr == ADDR_SKIP) begin
                skip_q <= req_i.wdata[CW-1:0];
            end else if (do_skip) begin
                skip_q <= skip_q - CW'(1);
            end
        end
    end

    // Sized once from the period in force at first start
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            qsize_q <= '0;
            qsize_set_q <= 1'b0;
        end else if (clk_en_i && start_cmd && !qsize_set_q) begin
            qsize_q <= period_q;
            qsize_set_q <= 1'b1;
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tx_due_o <= 1'b0;
            tx_skip_o <= 1'b0;
            dequeue_o <= 1'b0;
        end else if (clk_en_i) begin
            tx_due_o <= due && !do_skip;
            tx_skip_o <= do_skip;
            dequeue_o <= due && !(do_skip && spoint_q);
        end
    end

    // Collided event slot leaves count; others decrement
    assign lin_decr = lin_slot_i && !(lin_i.kind == SLOT_EVENT && lin_i.collision);

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            corrupt_q <= CW'(COUNT_RST);
        end else if (clk_en_i) begin
            if (req_i.wr && req_i.addr == ADDR_CORRUPT) begin
                corrupt_q <= req_i.wdata[CW-1:0];
            end else if (lin_decr && corrupt_q != '0) begin
                corrupt_q <= corrupt_q - CW'(1);
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            lin_checksum_o <= 8'h00;
            lin_corrupt_o <= 1'b0;
        end else if (clk_en_i && lin_slot_i) begin
            lin_corrupt_o <= corrupt_q != '0;
            lin_checksum_o <= (corrupt_q != '0) ? 8'(-lin_i.checksum) : lin_i.checksum;
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_o <= 32'h00000000;
        end else if (clk_en_i) begin
            rdata_o <= 32'h00000000;
            if (req_i.rd) begin
                unique case (req_i.addr)
                    ADDR_CTRL: rdata_o <= {28'h0000000, spoint_q, event_q, 2'b00};
                    ADDR_DELAY: rdata_o <= 32'(delay_cfg_q);
                    ADDR_PERIOD: rdata_o <= 32'(period_q);
                    ADDR_CORRUPT: rdata_o <= 32'(corrupt_q);
                    ADDR_SKIP: rdata_o <= 32'(skip_q);
                    ADDR_ID: rdata_o <= 32'(ident_q);
                    ADDR_STATUS: rdata_o <= {30'h00000000, state_q};
                    ADDR_QSIZE: rdata_o <= 32'(qsize_q);
                    default: rdata_o <= 32'h00000000;
                endcase
            end
        end
    end

    property p_skip_silent;
        @(posedge clock_i) disable iff (!rst_b_i) clk_en_i && do_skip |=> tx_skip_o && !tx_due_o;
    endproperty
    a_skip_silent: assert property (p_skip_silent) else $error("skip sent a frame");

    property p_skip_decr;
        @(posedge clock_i) disable iff (!rst_b_i)
            clk_en_i && do_skip && !(req_i.wr && req_i.addr == ADDR_SKIP) |=> skip_q == $past(skip_q) - CW'(1);
    endproperty
    a_skip_decr: assert property (p_skip_decr) else $error("skip count not decremented");

    property p_resume;
        @(posedge clock_i) disable iff (!rst_b_i) clk_en_i && due && skip_q == '0 |=> tx_due_o;
    endproperty
    a_resume: assert property (p_resume) else $error("due frame not sent");

    property p_no_event_tx;
        @(posedge clock_i) disable iff (!rst_b_i)
            clk_en_i && event_q && !(req_i.wr && req_i.addr == ADDR_SKIP)
            |=> !tx_due_o && !tx_skip_o && $stable(skip_q);
    endproperty
    a_no_event_tx: assert property (p_no_event_tx) else $error("event frame scheduled cyclically");

    property p_negate;
        @(posedge clock_i) disable iff (!rst_b_i)
            clk_en_i && lin_slot_i && corrupt_q != '0 |=> lin_checksum_o == 8'(-$past(lin_i.checksum));
    endproperty
    a_negate: assert property (p_negate) else $error("checksum not negated");

    property p_clean;
        @(posedge clock_i) disable iff (!rst_b_i)
            clk_en_i && lin_slot_i && corrupt_q == '0 |=> !lin_corrupt_o && lin_checksum_o == $past(lin_i.checksum);
    endproperty
    a_clean: assert property (p_clean) else $error("zero count corrupted");

    property p_collide_hold;
        @(posedge clock_i) disable iff (!rst_b_i)
            clk_en_i && lin_slot_i && lin_i.kind == SLOT_EVENT && lin_i.collision && !req_i.wr
            |=> $stable(corrupt_q);
    endproperty
    a_collide_hold: assert property (p_collide_hold) else $error("collision decremented count");

    property p_uncond_decr;
        @(posedge clock_i) disable iff (!rst_b_i)
            clk_en_i && lin_slot_i && lin_i.kind != SLOT_EVENT && corrupt_q != '0 && !req_i.wr
            |=> corrupt_q == $past(corrupt_q) - CW'(1);
    endproperty
    a_uncond_decr: assert property (p_uncond_decr) else $error("count not decremented");

    property p_reload;
        @(posedge clock_i) disable iff (!rst_b_i)
            clk_en_i && due && !restart && !stop_cmd |=> count_q == $past(period_q) && state_q == ST_CYCLIC;
    endproperty
    a_reload: assert property (p_reload) else $error("period not reloaded");

    property p_restart;
        @(posedge clock_i) disable iff (!rst_b_i) clk_en_i && restart && !stop_cmd |=> state_q == ST_FIRST;
    endproperty
    a_restart: assert property (p_restart) else $error("restart not taken");

    property p_qsize;
        @(posedge clock_i) disable iff (!rst_b_i) qsize_set_q |=> $stable(qsize_q);
    endproperty
    a_qsize: assert property (p_qsize) else $error("queue size changed");

    property p_qsize_first;
        @(posedge clock_i) disable iff (!rst_b_i)
            clk_en_i && start_cmd && !qsize_set_q |=> qsize_set_q && qsize_q == $past(period_q);
    endproperty
    a_qsize_first: assert property (p_qsize_first) else $error("queue size not taken at start");

    property p_first_load;
        @(posedge clock_i) disable iff (!rst_b_i)
            clk_en_i && start_cmd |=> state_q == ST_FIRST && count_q == $past(first_delay);
    endproperty
    a_first_load: assert property (p_first_load) else $error("first delay not loaded");

    property p_derived;
        @(posedge clock_i) disable iff (!rst_b_i)
            delay_cfg_q[CW-1] && period_q != '0 |-> first_delay < period_q;
    endproperty
    a_derived: assert property (p_derived) else $error("derived delay outside one period");

    property p_tick_dec;
        @(posedge clock_i) disable iff (!rst_b_i)
            clk_en_i && state_q != ST_IDLE && tick && count_q > CW'(1) && !restart && !stop_cmd
            |=> count_q == $past(count_q) - CW'(1);
    endproperty
    a_tick_dec: assert property (p_tick_dec) else $error("count not stepped on tick");

    property p_count_hold;
        @(posedge clock_i) disable iff (!rst_b_i)
            clk_en_i && !tick && !restart |=> $stable(count_q);
    endproperty
    a_count_hold: assert property (p_count_hold) else $error("count moved between ticks");

    property p_period_restart;
        @(posedge clock_i) disable iff (!rst_b_i)
            clk_en_i && period_wr && state_q != ST_IDLE
            |=> state_q == ST_FIRST && period_q == $past(req_i.wdata[CW-1:0]) && tick_cnt_q == '0;
    endproperty
    a_period_restart: assert property (p_period_restart) else $error("period write did not restart");

    property p_stop;
        @(posedge clock_i) disable iff (!rst_b_i)
            clk_en_i && stop_cmd && !start_cmd |=> state_q == ST_IDLE && !tx_due_o && !tx_skip_o;
    endproperty
    a_stop: assert property (p_stop) else $error("stopped frame still active");

    property p_skip_dequeue;
        @(posedge clock_i) disable iff (!rst_b_i)
            clk_en_i && do_skip |=> dequeue_o == !$past(spoint_q);
    endproperty
    a_skip_dequeue: assert property (p_skip_dequeue) else $error("skip dequeue wrong");

    property p_send_dequeue;
        @(posedge clock_i) disable iff (!rst_b_i)
            clk_en_i && due && !do_skip |=> tx_due_o && dequeue_o;
    endproperty
    a_send_dequeue: assert property (p_send_dequeue) else $error("send without dequeue");

    property p_skip_floor;
        @(posedge clock_i) disable iff (!rst_b_i)
            clk_en_i && skip_q == '0 && !(req_i.wr && req_i.addr == ADDR_SKIP) |=> skip_q == '0;
    endproperty
    a_skip_floor: assert property (p_skip_floor) else $error("skip count wrapped");

    property p_sole_event;
        @(posedge clock_i) disable iff (!rst_b_i)
            clk_en_i && lin_slot_i && lin_i.kind == SLOT_EVENT && !lin_i.collision && corrupt_q != '0 && !req_i.wr
            |=> corrupt_q == $past(corrupt_q) - CW'(1);
    endproperty
    a_sole_event: assert property (p_sole_event) else $error("sole responder not counted");

    property p_zero_stays;
        @(posedge clock_i) disable iff (!rst_b_i)
            clk_en_i && corrupt_q == '0 && !(req_i.wr && req_i.addr == ADDR_CORRUPT) |=> corrupt_q == '0;
    endproperty
    a_zero_stays: assert property (p_zero_stays) else $error("corrupt count wrapped");

    property p_pulse;
        @(posedge clock_i) disable iff (!rst_b_i) clk_en_i && tx_due_o |=> !tx_due_o;
    endproperty
    a_pulse: assert property (p_pulse) else $error("send pulse too long");

    // Enable low must hold every counter, or delays stretch unevenly
    property p_freeze;
        @(posedge clock_i) disable iff (!rst_b_i)
            !clk_en_i |=> $stable(state_q) && $stable(count_q) && $stable(tick_cnt_q)
            && $stable(skip_q) && $stable(corrupt_q) && $stable(lin_checksum_o);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while disabled");

    c_skip: cover property (@(posedge clock_i) disable iff (!rst_b_i) tx_skip_o);
    c_send: cover property (@(posedge clock_i) disable iff (!rst_b_i) tx_due_o);
    c_corrupt: cover property (@(posedge clock_i) disable iff (!rst_b_i) lin_corrupt_o);
    c_collide: cover property (@(posedge clock_i) disable iff (!rst_b_i) lin_slot_i && lin_i.collision);
    c_period_restart: cover property (@(posedge clock_i) disable iff (!rst_b_i) period_wr && state_q == ST_CYCLIC);
endmodule : frame_tx_scheduler
`default_nettype wire

// *** verif/lin_slot_source.sv ***
// Model of the LIN framer side: reports one slot per call of send.
// Assumes the scheduler looks at lin_o only while lin_slot_o is high.
`timescale 1ns/1ps
`default_nettype none
module lin_slot_source (
    // Clock
    input wire logic clock_i,
    // Slot report
    output logic lin_slot_o,
    output frame_sched_pkg::lin_slot_s lin_o
);
    import frame_sched_pkg::*;
    initial begin
        lin_slot_o = 1'b0;
        lin_o = '0;
    end
    task automatic send(input slot_kind_e k, input logic c, input logic [7:0] cs);
        @(posedge clock_i);
        lin_slot_o <= 1'b1;
        lin_o <= '{k, c, cs};
        @(posedge clock_i);
        lin_slot_o <= 1'b0;
        // Stale fields inverted so nobody leans on them
        lin_o <= ~lin_o;
    endtask : send
endmodule : lin_slot_source
`default_nettype wire

// *** verif/test_frame_tx_scheduler.sv ***
// Self-checking bench for the cyclic frame transmit scheduler.
// Assumes the slot model in lin_slot_source and a 200 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module test_frame_tx_scheduler;
    import frame_sched_pkg::*;
    logic clock_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic clk_en_i = 1'b1;
    reg_req_s req_i = '0;
    logic [31:0] rdata_o;
    logic tx_due_o, tx_skip_o, dequeue_o, lin_slot_i, lin_corrupt_o;
    lin_slot_s lin_i;
    logic [7:0] lin_checksum_o;
    int failures = 0;
    int num_checks = 0;
    int cyc = 0;
    int t0 = 0;
    int ev_cyc[$];
    bit ev_skip[$];
    bit single_pt = 1'b0;
    always #2.5 clock_i = ~clock_i;
    always @(posedge clock_i) cyc <= cyc + 1;
    frame_tx_scheduler i_frame_tx_scheduler (.clock_i(clock_i), .rst_b_i(rst_b_i), .clk_en_i(clk_en_i),
        .req_i(req_i), .rdata_o(rdata_o), .tx_due_o(tx_due_o), .tx_skip_o(tx_skip_o), .dequeue_o(dequeue_o),
        .lin_slot_i(lin_slot_i), .lin_i(lin_i), .lin_checksum_o(lin_checksum_o), .lin_corrupt_o(lin_corrupt_o));
    lin_slot_source i_lin_slot_source (.clock_i(clock_i), .lin_slot_o(lin_slot_i), .lin_o(lin_i));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic finish_test();
        if (failures == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finish_test
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock_i);
        req_i <= '{a, d, 1'b1, 1'b0};
        @(posedge clock_i);
        req_i.wr <= 1'b0;
        t0 = cyc;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clock_i);
        req_i <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clock_i);
        req_i.rd <= 1'b0;
        #1;
        chk(rdata_o, exp);
    endtask : rd
    // Event log is emptied first so the window only sees this run
    task automatic go(input logic [3:0] a, input logic [31:0] d);
        ev_cyc.delete();
        ev_skip.delete();
        wr(a, d);
    endtask : go
    task automatic expect_ev(input int d, input int p, input int n, input int skips);
        int first;
        first = (d < 1) ? 1 : d;
        // A silent run still waits out two due times
        repeat ((first + ((n == 0) ? 1 : n - 1) * p) * TICK_CYCLES + 10) @(posedge clock_i);
        chk(ev_cyc.size(), n);
        if (n > 0) begin
            chk(ev_cyc[0] - t0 > (first - 1) * TICK_CYCLES && ev_cyc[0] - t0 <= first * TICK_CYCLES + 4, 1);
        end
        for (int i = 0; i < n; i++) begin
            chk(ev_skip[i], i < skips);
            if (i > 0) chk(ev_cyc[i] - ev_cyc[i - 1], p * TICK_CYCLES);
        end
    endtask : expect_ev
    always @(posedge clock_i) begin
        if (tx_due_o === 1'b1 || tx_skip_o === 1'b1) begin
            ev_cyc.push_back(cyc);
            ev_skip.push_back(tx_skip_o);
            chk(dequeue_o, !(single_pt && tx_skip_o));
        end
    end
    initial begin
        int cnt;
        slot_kind_e k;
        logic c;
        logic [7:0] cs;
        cnt = $urandom(76759);
        repeat (8) @(posedge clock_i);
        rst_b_i <= 1'b1;
        rd(ADDR_PERIOD, PERIOD_RST);
        rd(ADDR_DELAY, DELAY_RST);
        rd(4'hF, 32'h0);
        rd(ADDR_STATUS, 32'h0);
        wr(ADDR_PERIOD, 32'h3);
        wr(ADDR_DELAY, 32'h2);
        wr(ADDR_SKIP, 32'h2);
        go(ADDR_CTRL, 32'h1);
        expect_ev(2, 3, 4, 2);
        rd(ADDR_STATUS, 32'h2);
        rd(ADDR_QSIZE, 32'h3);
        go(ADDR_PERIOD, 32'h4);
        rd(ADDR_STATUS, 32'h1);
        expect_ev(2, 4, 2, 0);
        rd(ADDR_QSIZE, 32'h3);
        wr(ADDR_CTRL, 32'h2);
        rd(ADDR_STATUS, 32'h0);
        wr(ADDR_DELAY, DELAY_RST);
        wr(ADDR_ID, 32'h7);
        go(ADDR_CTRL, 32'h1);
        expect_ev(3, 4, 2, 0);
        wr(ADDR_CTRL, 32'h2);
        wr(ADDR_SKIP, 32'h1);
        single_pt = 1'b1;
        go(ADDR_CTRL, 32'h9);
        expect_ev(3, 4, 2, 1);
        wr(ADDR_CTRL, 32'h2);
        single_pt = 1'b0;
        wr(ADDR_SKIP, 32'h1);
        go(ADDR_CTRL, 32'h5);
        expect_ev(3, 4, 0, 0);
        rd(ADDR_SKIP, 32'h1);
        wr(ADDR_CTRL, 32'h2);
        wr(ADDR_CORRUPT, 32'h6);
        cnt = 6;
        // Every slot kind, one collided event slot, then past zero
        for (int i = 0; i < 12; i++) begin
            k = slot_kind_e'(i % 4);
            c = (i == 2);
            cs = 8'($urandom);
            i_lin_slot_source.send(k, c, cs);
            #1;
            chk(lin_corrupt_o, cnt > 0);
            chk(lin_checksum_o, (cnt > 0) ? 8'(-cs) : cs);
            if (cnt > 0 && !c) cnt--;
        end
        rd(ADDR_CORRUPT, cnt);
        // Slot seen while disabled must change nothing
        wr(ADDR_CORRUPT, 32'h2);
        @(posedge clock_i);
        clk_en_i <= 1'b0;
        i_lin_slot_source.send(SLOT_UNCOND, 1'b0, ~cs);
        #1;
        chk(lin_checksum_o, cs);
        chk(lin_corrupt_o, 1'b0);
        @(posedge clock_i);
        clk_en_i <= 1'b1;
        rd(ADDR_CORRUPT, 32'h2);
        finish_test();
    end
    initial begin
        #200000;
        failures++;
        finish_test();
    end
endmodule : test_frame_tx_scheduler
`default_nettype wire
